// *** dlvr_ctrl.sv ***
`timescale 1ns/10ps
// Function
// - shared commands accepted without error
// - numeric one and ON are equal
// - default keyword restores default value, except sampling under a fast standard
// - alpha: copy luma/green or flat fields
// - mono in GBR copies green
// - mono leaves YCbCr output unchanged
// - nine sampling structure codes accepted
// - thirteen 1080-line standard codes accepted
// - boolean selects synthesis or conversion
// - twenty-five test pattern codes accepted
// - offset in microseconds, clock-cycle resolution
// - every setting has a query
// - conversion status returns standard and structure
// - offset symmetric range, one-period steps
// - fast progressive forces 4:2:2 10-bit
module dlvr_ctrl
	import dlvr_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       req_valid,
	input  wire dlvr_req_s  req,
	input  wire logic       module_addressed,
	input  wire dlvr_pix_s  pix_in,
	input  wire logic       pix_in_valid,
	output dlvr_resp_s      resp,
	output logic            resp_valid,
	output dlvr_pix_s       pix_out,
	output logic            pix_out_valid,
	output logic [3:0]      alpha_sel_reg,
	output logic            mono_reg,
	output logic [3:0]      samp_reg,
	output logic [3:0]      std_reg,
	output logic            synth_reg,
	output logic [4:0]      pattern_reg,
	output logic signed [4:0] link_b_horizontal_offset
);

	typedef enum logic [1:0] {
		DLVR_ST_IDLE = 2'b01,
		DLVR_ST_SEL  = 2'b10
	} dlvr_st_e;

	dlvr_st_e   state_reg;
	logic       bool_val;
	logic       is_set;
	logic       in_range;
	logic       fast_std;
	logic       ofs_load;
	logic [4:0] code;
	logic [4:0] limit;
	dlvr_resp_s resp_next;

	// boolean argument: ON keyword or nonzero numeric
	assign bool_val = (req.kind == DLVR_ARG_ON) ||
		(req.kind == DLVR_ARG_NUM && req.value != 32'sh0);
	assign code     = req.value[4:0];
	assign is_set   = req_valid && !req.query && state_reg == DLVR_ST_SEL;
	assign fast_std = std_reg <= DLVR_STD_LAST_FAST;
	assign ofs_load = is_set && req.cmd == DLVR_CMD_OFFSET;

	// code limit for the enumerated setting being written
	always_comb begin
		limit = 5'h00;
		unique case (req.cmd)
			DLVR_CMD_ALPHA:    limit = DLVR_ALPHA_CODES;
			DLVR_CMD_SAMPLING: limit = DLVR_SAMP_CODES;
			DLVR_CMD_STANDARD: limit = DLVR_STD_CODES;
			DLVR_CMD_PATTERN:  limit = DLVR_PAT_CODES;
			default:           limit = 5'h00;
		endcase
		in_range = req.kind == DLVR_ARG_DEF ||
			(req.value >= 32'sh0 && req.value < 32'(limit));
	end

	// addressing: select command latches whether this module is meant
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_reg <= DLVR_ST_IDLE;
		end else if (req_valid && req.cmd == DLVR_CMD_SELECT) begin
			state_reg <= module_addressed ? DLVR_ST_SEL : DLVR_ST_IDLE;
		end
	end

	// alpha source
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			alpha_sel_reg <= DLVR_RST_ALPHA;
		end else if (is_set && req.cmd == DLVR_CMD_ALPHA && in_range) begin
			alpha_sel_reg <= req.kind == DLVR_ARG_DEF ? DLVR_RST_ALPHA : code[3:0];
		end
	end

	// boolean settings
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mono_reg  <= DLVR_RST_MONO;
			synth_reg <= DLVR_RST_SYNTH;
		end else if (is_set) begin
			if (req.cmd == DLVR_CMD_MONO) begin
				mono_reg <= req.kind == DLVR_ARG_DEF ? DLVR_RST_MONO : bool_val;
			end
			if (req.cmd == DLVR_CMD_SYNTH) begin
				synth_reg <= req.kind == DLVR_ARG_DEF ? DLVR_RST_SYNTH : bool_val;
			end
		end
	end

	// standard and sampling structure, with the fast progressive lock
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			std_reg  <= DLVR_RST_STD;
			samp_reg <= DLVR_RST_SAMP;
		end else if (is_set && in_range) begin
			if (req.cmd == DLVR_CMD_STANDARD) begin
				std_reg <= req.kind == DLVR_ARG_DEF ? DLVR_RST_STD : code[3:0];
				if (req.kind != DLVR_ARG_DEF && code[3:0] <= DLVR_STD_LAST_FAST) begin
					samp_reg <= DLVR_SAMP_YCB422_10;
				end
			end else if (req.cmd == DLVR_CMD_SAMPLING && !fast_std) begin
				samp_reg <= req.kind == DLVR_ARG_DEF ? DLVR_RST_SAMP : code[3:0];
			end
		end
	end

	// test pattern
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pattern_reg <= DLVR_RST_PAT;
		end else if (is_set && req.cmd == DLVR_CMD_PATTERN && in_range) begin
			pattern_reg <= req.kind == DLVR_ARG_DEF ? DLVR_RST_PAT : code;
		end
	end

	// offset: default keyword means zero
	dlvr_ofs u_ofs (
		.clk   (clk),
		.rst   (rst),
		.load  (ofs_load),
		.units (req.kind == DLVR_ARG_DEF ? 32'sh0 : req.value),
		.steps (link_b_horizontal_offset)
	);

	// answers: one per request, queries carry the value
	always_comb begin
		resp_next = '0;
		if (req.query) begin
			unique case (req.cmd)
				DLVR_CMD_ALPHA:    resp_next.value = 32'(alpha_sel_reg);
				DLVR_CMD_MONO:     resp_next.value = 32'(mono_reg);
				DLVR_CMD_SAMPLING: resp_next.value = 32'(samp_reg);
				DLVR_CMD_STANDARD: resp_next.value = 32'(std_reg);
				DLVR_CMD_SYNTH:    resp_next.value = 32'(synth_reg);
				DLVR_CMD_PATTERN:  resp_next.value = 32'(pattern_reg);
				DLVR_CMD_OFFSET:   resp_next.value = 32'(link_b_horizontal_offset) *
					32'(DLVR_OFS_STEP_UNITS);
				DLVR_CMD_CONVSTAT: resp_next.value = {24'h0, std_reg, samp_reg};
				default:           resp_next.value = 32'sh0;
			endcase
		end else begin
			// shared and select never flag an error
			resp_next.error = (req.cmd == DLVR_CMD_ALPHA || req.cmd == DLVR_CMD_SAMPLING ||
				req.cmd == DLVR_CMD_STANDARD || req.cmd == DLVR_CMD_PATTERN) && !in_range
				|| (req.cmd == DLVR_CMD_SAMPLING && fast_std && req.kind != DLVR_ARG_DEF
				&& code[3:0] != DLVR_SAMP_YCB422_10);
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			resp       <= '0;
			resp_valid <= 1'b0;
		end else begin
			resp_valid <= req_valid;
			if (req_valid) begin
				resp <= resp_next;
			end
		end
	end

	// datapath: gbr space is sampling codes 0..2
	dlvr_mono u_mono (
		.clk           (clk),
		.rst           (rst),
		.pix_in        (pix_in),
		.pix_in_valid  (pix_in_valid),
		.mono_on       (mono_reg),
		.gbr_space     (samp_reg <= DLVR_SAMP_GBR444A10),
		.alpha_sel     (alpha_sel_reg),
		.pix_out       (pix_out),
		.pix_out_valid (pix_out_valid)
	);

	// addressing: nothing moves until this module is selected
	unsel_hold_a : assert property (@(posedge clk) disable iff (rst)
		state_reg == DLVR_ST_IDLE && !(req_valid && req.cmd == DLVR_CMD_SELECT)
		|=> $stable(alpha_sel_reg) && $stable(samp_reg) && $stable(std_reg))
		else $error("unselected command changed state");

	shared_ok_a : assert property (@(posedge clk) disable iff (rst)
		req_valid && req.cmd == DLVR_CMD_SHARED |=> resp_valid && !resp.error)
		else $error("shared command flagged");

	select_ok_a : assert property (@(posedge clk) disable iff (rst)
		req_valid && req.cmd == DLVR_CMD_SELECT |=> resp_valid && !resp.error)
		else $error("select command flagged");

	// boolean arguments: numeric one, ON and OFF
	bool_on_a : assert property (@(posedge clk) disable iff (rst)
		is_set && req.cmd == DLVR_CMD_SYNTH && req.kind == DLVR_ARG_NUM && req.value == 32'sh1
		|=> synth_reg)
		else $error("numeric one not taken as on");

	mono_on_a : assert property (@(posedge clk) disable iff (rst)
		is_set && req.cmd == DLVR_CMD_MONO && req.kind == DLVR_ARG_ON
		|=> mono_reg)
		else $error("on keyword not taken");

	synth_off_a : assert property (@(posedge clk) disable iff (rst)
		is_set && req.cmd == DLVR_CMD_SYNTH && req.kind == DLVR_ARG_OFF
		|=> !synth_reg)
		else $error("synthesis not turned off");

	// default keyword restores the reset value of each setting except sampling, which stays pinned under a fast standard
	def_alpha_a : assert property (@(posedge clk) disable iff (rst)
		is_set && req.cmd == DLVR_CMD_ALPHA && req.kind == DLVR_ARG_DEF
		|=> alpha_sel_reg == DLVR_RST_ALPHA)
		else $error("default not restored");

	def_std_a : assert property (@(posedge clk) disable iff (rst)
		is_set && req.cmd == DLVR_CMD_STANDARD && req.kind == DLVR_ARG_DEF
		|=> std_reg == DLVR_RST_STD)
		else $error("standard default not restored");

	def_synth_a : assert property (@(posedge clk) disable iff (rst)
		is_set && req.cmd == DLVR_CMD_SYNTH && req.kind == DLVR_ARG_DEF
		|=> synth_reg == DLVR_RST_SYNTH)
		else $error("synthesis default not restored");

	def_offset_a : assert property (@(posedge clk) disable iff (rst)
		is_set && req.cmd == DLVR_CMD_OFFSET && req.kind == DLVR_ARG_DEF
		|=> link_b_horizontal_offset == 5'sh00)
		else $error("offset default not zero");

	// enumerated settings: store in range, refuse past the end
	alpha_store_a : assert property (@(posedge clk) disable iff (rst)
		is_set && req.cmd == DLVR_CMD_ALPHA && req.kind == DLVR_ARG_NUM && in_range
		|=> alpha_sel_reg == $past(req.value[3:0]))
		else $error("alpha code not stored");

	pat_store_a : assert property (@(posedge clk) disable iff (rst)
		is_set && req.cmd == DLVR_CMD_PATTERN && req.kind == DLVR_ARG_NUM && in_range
		|=> pattern_reg == $past(req.value[4:0]))
		else $error("pattern code not stored");

	samp_refuse_a : assert property (@(posedge clk) disable iff (rst)
		is_set && req.cmd == DLVR_CMD_SAMPLING && !in_range
		|=> resp.error && $stable(samp_reg))
		else $error("bad structure code taken");

	std_refuse_a : assert property (@(posedge clk) disable iff (rst)
		is_set && req.cmd == DLVR_CMD_STANDARD && !in_range
		|=> resp.error && $stable(std_reg))
		else $error("bad standard code taken");

	codes_range_a : assert property (@(posedge clk) disable iff (rst)
		alpha_sel_reg < 4'(DLVR_ALPHA_CODES) && samp_reg < 4'(DLVR_SAMP_CODES)
		&& std_reg < 4'(DLVR_STD_CODES) && pattern_reg < DLVR_PAT_CODES)
		else $error("setting outside code list");

	// answers: one per request, queries carry the stored value
	query_ok_a : assert property (@(posedge clk) disable iff (rst)
		req_valid && req.query |=> resp_valid && !resp.error)
		else $error("query not answered cleanly");

	resp_idle_a : assert property (@(posedge clk) disable iff (rst)
		!req_valid |=> !resp_valid)
		else $error("answer without request");

	query_val_a : assert property (@(posedge clk) disable iff (rst)
		req_valid && req.query && req.cmd == DLVR_CMD_STANDARD
		|=> resp_valid && resp.value == 32'($past(std_reg)))
		else $error("standard query wrong");

	pat_query_a : assert property (@(posedge clk) disable iff (rst)
		req_valid && req.query && req.cmd == DLVR_CMD_PATTERN
		|=> resp_valid && resp.value == 32'($past(pattern_reg)))
		else $error("pattern query wrong");

	conv_status_a : assert property (@(posedge clk) disable iff (rst)
		req_valid && req.query && req.cmd == DLVR_CMD_CONVSTAT
		|=> resp.value[7:0] == {$past(std_reg), $past(samp_reg)})
		else $error("status query wrong");

	// fast progressive standards pin the structure
	fast_lock_a : assert property (@(posedge clk) disable iff (rst)
		fast_std |-> samp_reg == DLVR_SAMP_YCB422_10)
		else $error("fast standard structure not forced");

	fast_refuse_a : assert property (@(posedge clk) disable iff (rst)
		is_set && req.cmd == DLVR_CMD_SAMPLING && fast_std && req.kind == DLVR_ARG_NUM
		&& req.value[3:0] != DLVR_SAMP_YCB422_10 |=> resp.error)
		else $error("fast standard structure not refused");

endmodule : dlvr_ctrl

// *** dlvr_ctrl_bench.sv ***
`timescale 1ns/10ps
// command and pixel sequences against the interpreter
module dlvr_ctrl_bench;
	import dlvr_pkg::*;
	logic             clk;
	logic             rst;
	logic             req_valid;
	logic             module_addressed;
	logic             pix_in_valid;
	logic             pix_out_valid;
	logic             resp_valid;
	logic             mono_reg;
	logic             synth_reg;
	logic [3:0]       alpha_sel_reg;
	logic [3:0]       samp_reg;
	logic [3:0]       std_reg;
	logic [4:0]       pattern_reg;
	logic signed [4:0] ofs;
	dlvr_req_s        req;
	dlvr_resp_s       resp;
	dlvr_pix_s        pix_in;
	dlvr_pix_s        pix_out;
	dlvr_resp_s       sel_r;
	logic             sel_g;
	int               mismatches;
	int               cmp_count;
	dlvr_cmd_e        cs[4] = '{DLVR_CMD_ALPHA, DLVR_CMD_SAMPLING, DLVR_CMD_STANDARD,
		DLVR_CMD_PATTERN};
	int               ns[4] = '{12, 9, 13, 25};
	int               ou[6] = '{269, 67, 68, -68, 2020, -5000};
	int               os[6] = '{2, 0, 1, -1, 15, -15};

	dlvr_ctrl dlvr_ctrl_i (.clk(clk), .rst(rst), .req_valid(req_valid), .req(req),
		.module_addressed(module_addressed), .pix_in(pix_in), .pix_in_valid(pix_in_valid),
		.resp(resp), .resp_valid(resp_valid), .pix_out(pix_out),
		.pix_out_valid(pix_out_valid), .alpha_sel_reg(alpha_sel_reg), .mono_reg(mono_reg),
		.samp_reg(samp_reg), .std_reg(std_reg), .synth_reg(synth_reg),
		.pattern_reg(pattern_reg), .link_b_horizontal_offset(ofs));
	dlvr_host dlvr_host_i (.clk(clk), .resp(resp), .resp_valid(resp_valid),
		.req_valid(req_valid), .req(req), .module_addressed(module_addressed));

	// 100 MHz
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic give_verdict;
		$display("compares %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : give_verdict

	task automatic chk(input string name, input logic [47:0] exp, input logic [47:0] got);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	// set command: answer must come and carry the expected error flag
	task automatic run(input dlvr_cmd_e c, input dlvr_arg_e k, input int v, input logic e);
		dlvr_resp_s r;
		logic g;
		dlvr_host_i.xfer(c, 1'b0, k, v, 1'b1, r, g);
		chk("resp_valid", 48'h1, {47'h0, g});
		chk("error", {47'h0, e}, {47'h0, r.error});
	endtask : run

	task automatic qry(input dlvr_cmd_e c, input int v);
		dlvr_resp_s r;
		logic g;
		dlvr_host_i.xfer(c, 1'b1, DLVR_ARG_NUM, 0, 1'b1, r, g);
		chk("query_valid", 48'h1, {47'h0, g});
		chk("query", {16'h0, 32'(v)}, {16'h0, r.value});
	endtask : qry

	// one sample in, registered sample out one cycle later
	task automatic pix(input dlvr_pix_s p, input logic [47:0] e);
		@(posedge clk);
		pix_in <= p;
		pix_in_valid <= 1'b1;
		@(posedge clk);
		pix_in_valid <= 1'b0;
		pix_in <= ~p;
		#1;
		chk("pix_valid", 48'h1, {47'h0, pix_out_valid});
		chk("pix", e, pix_out);
	endtask : pix

	// watchdog well beyond the roughly 360 cycles the sequence needs
	initial begin
		#200000;
		mismatches++;
		give_verdict();
	end

	initial begin
		rst = 1'b1;
		pix_in = '0;
		pix_in_valid = 1'b0;
		mismatches = 0;
		cmp_count = 0;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		#1;
		chk("defaults", 48'h0000_0000_2440, {24'h0, alpha_sel_reg, mono_reg, samp_reg,
			std_reg, synth_reg, pattern_reg, ofs});
		// unselected set is answered quietly and ignored
		run(DLVR_CMD_SYNTH, DLVR_ARG_OFF, 0, 1'b0);
		chk("synth_unsel", 48'h1, {47'h0, synth_reg});
		run(DLVR_CMD_SELECT, DLVR_ARG_NUM, 0, 1'b0);
		run(DLVR_CMD_SHARED, DLVR_ARG_NUM, 5, 1'b0);
		// numeric and keyword booleans alternate
		run(DLVR_CMD_SYNTH, DLVR_ARG_NUM, 0, 1'b0);
		qry(DLVR_CMD_SYNTH, 0);
		run(DLVR_CMD_SYNTH, DLVR_ARG_ON, 0, 1'b0);
		qry(DLVR_CMD_SYNTH, 1);
		run(DLVR_CMD_SYNTH, DLVR_ARG_OFF, 0, 1'b0);
		run(DLVR_CMD_SYNTH, DLVR_ARG_NUM, 1, 1'b0);
		chk("synth", 48'h1, {47'h0, synth_reg});
		run(DLVR_CMD_MONO, DLVR_ARG_ON, 0, 1'b0);
		run(DLVR_CMD_MONO, DLVR_ARG_DEF, 0, 1'b0);
		qry(DLVR_CMD_MONO, 0);
		// every code of each list, then the first code past the end
		for (int j = 0; j < 4; j++) begin
			for (int i = 0; i < ns[j]; i++) begin
				run(cs[j], DLVR_ARG_NUM, i, 1'b0);
				qry(cs[j], i);
			end
			run(cs[j], DLVR_ARG_NUM, ns[j], 1'b1);
			qry(cs[j], ns[j] - 1);
		end
		run(DLVR_CMD_PATTERN, DLVR_ARG_DEF, 0, 1'b0);
		qry(DLVR_CMD_PATTERN, 2);
		// fast progressive pins the structure, the pinned code stays legal
		run(DLVR_CMD_STANDARD, DLVR_ARG_NUM, 0, 1'b0);
		qry(DLVR_CMD_SAMPLING, 7);
		run(DLVR_CMD_SAMPLING, DLVR_ARG_NUM, 0, 1'b1);
		run(DLVR_CMD_SAMPLING, DLVR_ARG_NUM, 7, 1'b0);
		qry(DLVR_CMD_CONVSTAT, 32'h07);
		run(DLVR_CMD_STANDARD, DLVR_ARG_DEF, 0, 1'b0);
		qry(DLVR_CMD_STANDARD, 4);
		run(DLVR_CMD_SAMPLING, DLVR_ARG_NUM, 2, 1'b0);
		qry(DLVR_CMD_CONVSTAT, 32'h42);
		run(DLVR_CMD_ALPHA, DLVR_ARG_NUM, 5, 1'b0);
		run(DLVR_CMD_ALPHA, DLVR_ARG_DEF, 0, 1'b0);
		qry(DLVR_CMD_ALPHA, 0);
		// rounding at the half step, sign, the top step, and clamping at the negative end
		for (int i = 0; i < 6; i++) begin
			run(DLVR_CMD_OFFSET, DLVR_ARG_NUM, ou[i], 1'b0);
			chk("offset", 48'(os[i]), 48'(ofs));
			qry(DLVR_CMD_OFFSET, os[i] * 135);
		end
		run(DLVR_CMD_OFFSET, DLVR_ARG_DEF, 0, 1'b0);
		chk("offset_def", 48'h0, 48'(ofs));
		// mono in GBR copies green, alpha copies green, then a flat field
		run(DLVR_CMD_MONO, DLVR_ARG_ON, 0, 1'b0);
		pix(48'h123456789ABC, 48'h123123123123);
		run(DLVR_CMD_ALPHA, DLVR_ARG_NUM, 6, 1'b0);
		pix(48'h123456789ABC, 48'h1231231237FD);
		run(DLVR_CMD_ALPHA, DLVR_ARG_NUM, 11, 1'b0);
		pix(48'h123456789ABC, 48'h123123123FFA);
		run(DLVR_CMD_SAMPLING, DLVR_ARG_NUM, 3, 1'b0);
		pix(48'h123456789ABC, 48'h123456789FFA);
		// another module selected: sets are answered but change nothing
		dlvr_host_i.xfer(DLVR_CMD_SELECT, 1'b0, DLVR_ARG_NUM, 0, 1'b0, sel_r,
			sel_g);
		chk("deselect", 48'h1, {47'h0, sel_g});
		run(DLVR_CMD_ALPHA, DLVR_ARG_NUM, 3, 1'b0);
		qry(DLVR_CMD_ALPHA, 11);
		give_verdict();
	end
endmodule : dlvr_ctrl_bench

// *** dlvr_host.sv ***
`timescale 1ns/10ps
// remote controller: one parsed command, then waits for the answer
module dlvr_host
	import dlvr_pkg::*;
(
	input  wire logic       clk,
	input  wire dlvr_resp_s resp,
	input  wire logic       resp_valid,
	output logic            req_valid,
	output dlvr_req_s       req,
	output logic            module_addressed
);
	// quiet until the first command
	initial begin
		req_valid = 1'b0;
		req = '0;
		module_addressed = 1'b0;
	end

	// held for one edge, then scrambled so a stale request never looks valid
	// callers send the select first; earlier commands only probe that unselected sets are ignored
	task automatic xfer(input dlvr_cmd_e c, input logic q, input dlvr_arg_e k, input int v,
		input logic addr, output dlvr_resp_s r, output logic got);
		@(posedge clk);
		req_valid <= 1'b1;
		req <= '{cmd: c, query: q, kind: k, value: v};
		module_addressed <= addr;
		@(posedge clk);
		req_valid <= 1'b0;
		req <= ~req;
		module_addressed <= ~addr;
		#1;
		got = resp_valid;
		r = resp;
	endtask : xfer
endmodule : dlvr_host

// *** dlvr_mono.sv ***
`timescale 1ns/10ps
// monochrome and alpha stage for one registered sample
module dlvr_mono
	import dlvr_pkg::*;
(
	input  wire logic      clk,
	input  wire logic      rst,
	input  wire dlvr_pix_s pix_in,
	input  wire logic      pix_in_valid,
	input  wire logic      mono_on,
	input  wire logic      gbr_space,
	input  wire logic [3:0] alpha_sel,
	output dlvr_pix_s      pix_out,
	output logic           pix_out_valid
);

	dlvr_pix_s pix_next;

	// green spread to blue and red only in GBR space
	always_comb begin
		pix_next = pix_in;
		if (mono_on && gbr_space) begin
			pix_next.b = pix_in.g;
			pix_next.r = pix_in.g;
		end
		// ycbcr leaves mono off the path entirely
		if (alpha_sel == DLVR_ALPHA_COPY) begin
			pix_next.a = pix_in.g;
		end else begin
			pix_next.a = 12'(DLVR_ALPHA_STEP * 12'(alpha_sel - 4'h1));
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pix_out       <= '0;
			pix_out_valid <= 1'b0;
		end else begin
			pix_out       <= pix_next;
			pix_out_valid <= pix_in_valid;
		end
	end

	mono_copy_a : assert property (@(posedge clk) disable iff (rst)
		pix_in_valid && mono_on && gbr_space |=> pix_out.b == pix_out.g && pix_out.r == pix_out.g)
		else $error("mono copy missing");

	ycc_pass_a : assert property (@(posedge clk) disable iff (rst)
		!gbr_space |=> pix_out.b == $past(pix_in.b) && pix_out.r == $past(pix_in.r))
		else $error("ycbcr sample changed");

endmodule : dlvr_mono

// *** dlvr_ofs.sv ***
`timescale 1ns/10ps
// microsecond value to signed clock-step offset, rounded and clamped
module dlvr_ofs
	import dlvr_pkg::*;
(
	input  wire logic               clk,
	input  wire logic               rst,
	input  wire logic               load,
	input  wire logic signed [31:0] units,
	output logic signed [4:0]       steps
);

	logic signed [31:0] mag;
	logic signed [31:0] q;
	logic               neg;

	// round half away from zero, then clamp
	always_comb begin
		neg = units[31];
		mag = neg ? -units : units;
		q   = (mag + 32'(DLVR_OFS_STEP_UNITS / 2)) / 32'(DLVR_OFS_STEP_UNITS);
		if (q > 32'(DLVR_OFS_MAX_STEPS)) begin
			q = 32'(DLVR_OFS_MAX_STEPS);
		end
		if (neg) begin
			q = -q;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			steps <= '0;
		end else if (load) begin
			steps <= q[4:0];
		end
	end

	ofs_range_a : assert property (@(posedge clk) disable iff (rst)
		steps <= DLVR_OFS_MAX && steps >= -DLVR_OFS_MAX)
		else $error("offset out of range");

endmodule : dlvr_ofs

// *** dlvr_pkg.sv ***
package dlvr_pkg;

	// command classes seen at the command port
	typedef enum logic [3:0] {
		DLVR_CMD_SELECT   = 4'h0,
		DLVR_CMD_ALPHA    = 4'h1,
		DLVR_CMD_MONO     = 4'h2,
		DLVR_CMD_SAMPLING = 4'h3,
		DLVR_CMD_STANDARD = 4'h4,
		DLVR_CMD_SYNTH    = 4'h5,
		DLVR_CMD_PATTERN  = 4'h6,
		DLVR_CMD_OFFSET   = 4'h7,
		DLVR_CMD_CONVSTAT = 4'h8,
		DLVR_CMD_SHARED   = 4'h9
	} dlvr_cmd_e;

	// argument kinds: numeric, keyword, default keyword
	typedef enum logic [1:0] {
		DLVR_ARG_NUM  = 2'h0,
		DLVR_ARG_ON   = 2'h1,
		DLVR_ARG_OFF  = 2'h2,
		DLVR_ARG_DEF  = 2'h3
	} dlvr_arg_e;

	// one parsed command from the transport
	typedef struct packed {
		dlvr_cmd_e        cmd;
		logic             query;
		dlvr_arg_e        kind;
		logic signed [31:0] value;
	} dlvr_req_s;

	// one answer back to the transport
	typedef struct packed {
		logic             error;
		logic signed [31:0] value;
	} dlvr_resp_s;

	// video sample: G/Y, B/Cb, R/Cr, alpha, 12 bits each
	typedef struct packed {
		logic [11:0] g;
		logic [11:0] b;
		logic [11:0] r;
		logic [11:0] a;
	} dlvr_pix_s;

	// value counts
	localparam logic [4:0]  DLVR_ALPHA_CODES    = 5'h0C;
	localparam logic [4:0]  DLVR_SAMP_CODES     = 5'h09;
	localparam logic [4:0]  DLVR_STD_CODES      = 5'h0D;
	localparam logic [4:0]  DLVR_PAT_CODES      = 5'h19;

	// alpha codes: 0 copies luma/green, 1..11 are 0%..100% flat field
	localparam logic [3:0]  DLVR_ALPHA_COPY     = 4'h0;
	localparam logic [11:0] DLVR_ALPHA_STEP     = 12'h199; // 10% of 12-bit full scale

	// sampling codes in list order
	localparam logic [3:0]  DLVR_SAMP_GBR444_12 = 4'h0;
	localparam logic [3:0]  DLVR_SAMP_GBR444A10 = 4'h2;
	localparam logic [3:0]  DLVR_SAMP_YCB422_10 = 4'h7;

	// standard codes: 0..2 are the 60, 59.94 and 50 Hz progressive ones
	localparam logic [3:0]  DLVR_STD_59I        = 4'h4;
	localparam logic [3:0]  DLVR_STD_LAST_FAST  = 4'h2;

	// defaults
	localparam logic [3:0]  DLVR_RST_ALPHA      = 4'h0;
	localparam logic [3:0]  DLVR_RST_SAMP       = DLVR_SAMP_GBR444_12;
	localparam logic [3:0]  DLVR_RST_STD        = DLVR_STD_59I;
	localparam logic [4:0]  DLVR_RST_PAT        = 5'h02;
	localparam logic        DLVR_RST_SYNTH      = 1'b1;
	localparam logic        DLVR_RST_MONO       = 1'b0;

	// link offset: value in units of 0.0001 us; step is one link clock period
	localparam int          DLVR_OFS_STEP_UNITS = 135;
	localparam int          DLVR_OFS_MAX_STEPS  = 15;  // 15 x 0.0135 = 0.2025 us
	localparam logic signed [4:0] DLVR_OFS_MAX  = 5'sh0F;

endpackage : dlvr_pkg
